/* File: src/spd_defines.vh */
// Constants for the pass-through parameter block decoder
`ifndef SPD_DEFINES_VH
`define SPD_DEFINES_VH
`define SPD_OFS_IDENT 5'h00
`define SPD_OFS_OPTS 5'h04
`define SPD_OFS_ADDR 5'h08
`define SPD_OFS_COUNT 5'h0c
`define SPD_OFS_CDB 5'h10
`define SPD_BLOCK_WORDS 7
`define SPD_F2_MSGONLY 0
`define SPD_F2_SUPPRESS 1
`define SPD_F2_QLO 2
`define SPD_F2_QHI 3
`define SPD_F1_OVERRIDE 0
`define SPD_F1_PAYLOAD 1
`define SPD_F1_TOTARGET 2
`define SPD_Q_SIMPLE 2'h0
`define SPD_Q_ORDERED 2'h1
`define SPD_Q_HEAD 2'h2
`define SPD_Q_RESERVED 2'h3
`define SPD_MSG_SIMPLE 8'h20
`define SPD_MSG_HEAD 8'h21
`define SPD_MSG_ORDERED 8'h22
`define SPD_MSG_ABORT 8'h06
`define SPD_MSG_BDR 8'h0c
`define SPD_MSG_CLRQ 8'h0e
`define SPD_ERR_NONE 8'h00
`define SPD_ERR_INVALID 8'h01
`define SPD_ERR_PHASE 8'h24
`define SPD_ERR_OVERRUN 8'h25
`define SPD_PH_DOUT 3'h0
`define SPD_PH_DIN 3'h1
`define SPD_PH_CMD 3'h2
`define SPD_PH_STAT 3'h3
`define SPD_PH_MOUT 3'h6
`define SPD_PH_MIN 3'h7
`endif

/* File: src/spd_decoder.v */
// Pass-through parameter block decoder and initiator sequencer
`timescale 1ns/1ps
`include "spd_defines.vh"
module spd_decoder #(
  parameter ADDR_W = 32,
  parameter COUNT_W = 32
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rstn_in,
  // Parameter block words from the host side
  input wire blk_wr_in,
  input wire [4:0] blk_ofs_in,
  input wire [31:0] blk_data_in,
  input wire blk_go_in,
  // Board options
  input wire global_release_permit_in,
  input wire unit_tagging_enabled_in,
  // Target side
  input wire [2:0] tgt_phase_in,
  input wire tgt_req_in,
  input wire tgt_done_in,
  // Command issue
  output wire busy_out,
  output reg sel_valid_out,
  output reg [7:0] sel_target_out,
  output reg [2:0] sel_unit_out,
  output reg allow_disconnect_out,
  output reg tag_valid_out,
  output reg [7:0] tag_msg_out,
  output reg msg_valid_out,
  output reg [7:0] msg_code_out,
  output reg cdb_valid_out,
  output reg [7:0] cdb_byte_out,
  // Data phase
  output reg payload_present_out,
  output reg to_target_out,
  output reg [ADDR_W-1:0] xfer_addr_out,
  output reg xfer_ack_out,
  // Completion
  output reg done_out,
  output reg [7:0] error_code_out,
  output reg [31:0] ident_out
);

  localparam ST_IDLE = 3'h0;
  localparam ST_SEL = 3'h1;
  localparam ST_MSG = 3'h2;
  localparam ST_CDB = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_END = 3'h5;

  reg [31:0] blk [0:`SPD_BLOCK_WORDS-1];
  reg [2:0] state;
  reg [3:0] cdb_idx;
  reg [COUNT_W-1:0] moved;

  // Target pins are not timed to clk_sys_in: three stages each, and a change
  // is taken only once stages two and three agree, so a glitch shorter than
  // one clock never reaches the sequencer. Costs four cycles of latency.
  reg [2:0] ph_s1;
  reg [2:0] ph_s2;
  reg [2:0] ph_s3;
  reg [2:0] ph_f;
  reg req_s1;
  reg req_s2;
  reg req_s3;
  reg req_f;
  reg req_prev;
  reg tdone_s1;
  reg tdone_s2;
  reg tdone_s3;
  reg tdone_f;
  wire req_rise;

  // Default data-phase table for opcodes 60H and up: {present, to_target}
  function [1:0] spd_default;
    input [7:0] op;
    begin
      case (op)
        8'haa, 8'hae, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb6: spd_default = 2'h3;
        8'ha4, 8'ha8, 8'hb5, 8'hb7, 8'hb8, 8'hc2, 8'hc3, 8'he4: spd_default = 2'h2;
        default: spd_default = 2'h0;
      endcase
    end
  endfunction

  // Descriptor length from the opcode group
  function [3:0] spd_cdb_len;
    input [7:0] op;
    begin
      case (op[7:5])
        3'h0: spd_cdb_len = 4'h6;
        3'h1, 3'h2: spd_cdb_len = 4'ha;
        default: spd_cdb_len = 4'hc;
      endcase
    end
  endfunction

  wire [7:0] f2 = blk[1][7:0];
  wire [7:0] f1 = blk[1][15:8];
  wire [7:0] tgt_id = blk[1][31:24];
  wire msg_only = f2[`SPD_F2_MSGONLY];
  wire [7:0] opcode = blk[4][7:0];
  wire [1:0] qkind = f2[`SPD_F2_QHI:`SPD_F2_QLO];
  wire [1:0] dflt = spd_default(opcode);
  wire [COUNT_W-1:0] count = blk[3][COUNT_W-1:0];
  wire [3:0] cdb_len = spd_cdb_len(opcode);
  wire msg_legal = (blk[4][7:0] == `SPD_MSG_ABORT) ||
                   (blk[4][7:0] == `SPD_MSG_BDR) ||
                   (blk[4][7:0] == `SPD_MSG_CLRQ);
  wire next_present = f1[`SPD_F1_OVERRIDE] ? f1[`SPD_F1_PAYLOAD] : dflt[1];
  wire next_to_tgt = f1[`SPD_F1_OVERRIDE] ? f1[`SPD_F1_TOTARGET] : dflt[0];
  wire data_phase = (ph_f == `SPD_PH_DOUT) || (ph_f == `SPD_PH_DIN);
  wire dir_ok = (ph_f == `SPD_PH_DOUT) == to_target_out;

  assign busy_out = (state != ST_IDLE);

  // One request per rising edge, so a held request is never counted twice
  assign req_rise = req_f & ~req_prev;

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ph_s1 <= `SPD_PH_STAT;
      ph_s2 <= `SPD_PH_STAT;
      ph_s3 <= `SPD_PH_STAT;
      ph_f <= `SPD_PH_STAT;
    end else begin
      ph_s1 <= tgt_phase_in;
      ph_s2 <= ph_s1;
      ph_s3 <= ph_s2;
      if (ph_s2 == ph_s3)
        ph_f <= ph_s3;
    end
  end

  // Reset to the idle level so no false edge follows reset
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      req_f <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      req_s1 <= tgt_req_in;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 == req_s3)
        req_f <= req_s3;
      req_prev <= req_f;
    end
  end

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tdone_s1 <= 1'b0;
      tdone_s2 <= 1'b0;
      tdone_s3 <= 1'b0;
      tdone_f <= 1'b0;
    end else begin
      tdone_s1 <= tgt_done_in;
      tdone_s2 <= tdone_s1;
      tdone_s3 <= tdone_s2;
      if (tdone_s2 == tdone_s3)
        tdone_f <= tdone_s3;
    end
  end

  // Block words captured only while idle; a running command is never disturbed
  always @(posedge clk_sys_in) begin
    if (blk_wr_in && state == ST_IDLE && blk_ofs_in[4:2] < `SPD_BLOCK_WORDS)
      blk[blk_ofs_in[4:2]] <= blk_data_in;
  end

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      cdb_idx <= 4'h0;
      moved <= {COUNT_W{1'b0}};
      sel_valid_out <= 1'b0;
      sel_target_out <= 8'h00;
      sel_unit_out <= 3'h0;
      allow_disconnect_out <= 1'b0;
      tag_valid_out <= 1'b0;
      tag_msg_out <= 8'h00;
      msg_valid_out <= 1'b0;
      msg_code_out <= 8'h00;
      cdb_valid_out <= 1'b0;
      cdb_byte_out <= 8'h00;
      payload_present_out <= 1'b0;
      to_target_out <= 1'b0;
      xfer_addr_out <= {ADDR_W{1'b0}};
      xfer_ack_out <= 1'b0;
      done_out <= 1'b0;
      error_code_out <= `SPD_ERR_NONE;
      ident_out <= 32'h0000_0000;
    end else begin
      sel_valid_out <= 1'b0;
      tag_valid_out <= 1'b0;
      msg_valid_out <= 1'b0;
      cdb_valid_out <= 1'b0;
      xfer_ack_out <= 1'b0;
      done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (blk_go_in) begin
            ident_out <= blk[0];
            sel_target_out <= tgt_id;
            moved <= {COUNT_W{1'b0}};
            cdb_idx <= 4'h0;
            error_code_out <= `SPD_ERR_NONE;
            if (msg_only) begin
              // Only identifier, target, code and unit are looked at
              sel_unit_out <= blk[4][15:13];
              msg_code_out <= blk[4][7:0];
              allow_disconnect_out <= 1'b0;
              payload_present_out <= 1'b0;
              to_target_out <= 1'b0;
              if (msg_legal) begin
                sel_valid_out <= 1'b1;
                state <= ST_MSG;
              end else begin
                error_code_out <= `SPD_ERR_INVALID;
                state <= ST_END;
              end
            end else begin
              sel_unit_out <= blk[4][15:13];
              allow_disconnect_out <= global_release_permit_in &
                                      ~f2[`SPD_F2_SUPPRESS];
              payload_present_out <= next_present;
              to_target_out <= next_to_tgt;
              // Address only matters with a data phase
              if (next_present)
                xfer_addr_out <= blk[2][ADDR_W-1:0];
              sel_valid_out <= 1'b1;
              state <= ST_SEL;
            end
          end
        end
        ST_SEL: begin
          // Tag message precedes the descriptor when unit tagging is on and the queue kind is not reserved
          if (unit_tagging_enabled_in && qkind != `SPD_Q_RESERVED) begin
            tag_valid_out <= 1'b1;
            case (qkind)
              `SPD_Q_SIMPLE: tag_msg_out <= `SPD_MSG_SIMPLE;
              `SPD_Q_ORDERED: tag_msg_out <= `SPD_MSG_ORDERED;
              default: tag_msg_out <= `SPD_MSG_HEAD;
            endcase
          end
          state <= ST_CDB;
        end
        ST_MSG: begin
          msg_valid_out <= 1'b1;
          state <= ST_END;
        end
        ST_CDB: begin
          cdb_valid_out <= 1'b1;
          cdb_byte_out <= blk[4 + cdb_idx[3:2]][8*cdb_idx[1:0] +: 8];
          if (cdb_idx == cdb_len - 4'h1)
            state <= ST_DATA;
          cdb_idx <= cdb_idx + 4'h1;
        end
        ST_DATA: begin
          if (tdone_f) begin
            state <= ST_END;
          end else if (req_rise && data_phase) begin
            if (!payload_present_out || !dir_ok) begin
              error_code_out <= `SPD_ERR_PHASE;
              state <= ST_END;
            end else if (count != {COUNT_W{1'b0}} && moved == count) begin
              error_code_out <= `SPD_ERR_OVERRUN;
              state <= ST_END;
            end else begin
              // Zero count never reaches the cap test above
              xfer_ack_out <= 1'b1;
              xfer_addr_out <= xfer_addr_out + {{(ADDR_W-1){1'b0}}, 1'b1};
              moved <= moved + {{(COUNT_W-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_END: begin
          done_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: test/spd_decoder_chk.sv */
// Assertion checker for the parameter block decoder
`timescale 1ns/1ps
module spd_chk(
  input wire clk_sys_in, input wire rstn_in, input wire blk_go_in,
  input wire global_release_permit_in, input wire unit_tagging_enabled_in,
  input wire busy_out, input wire sel_valid_out, input wire allow_disconnect_out,
  input wire tag_valid_out, input wire [7:0] tag_msg_out, input wire msg_valid_out,
  input wire cdb_valid_out, input wire payload_present_out, input wire xfer_ack_out,
  input wire done_out);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  property p_go; blk_go_in && !busy_out |-> ##[1:2] (sel_valid_out || done_out); endproperty
  a_go: assert property (p_go) else $error("go not answered");
  property p_msg; msg_valid_out |-> !cdb_valid_out ##1 done_out; endproperty
  a_msg: assert property (p_msg) else $error("message not closed");
  property p_tag; tag_valid_out |-> tag_msg_out inside {8'h20, 8'h21, 8'h22}; endproperty
  a_tag: assert property (p_tag) else $error("bad tag code");
  property p_tagen; tag_valid_out |-> unit_tagging_enabled_in; endproperty
  a_tagen: assert property (p_tagen) else $error("tag while disabled");
  property p_disc; sel_valid_out && allow_disconnect_out |-> global_release_permit_in;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect without permit");
  property p_ack; xfer_ack_out |-> payload_present_out && busy_out; endproperty
  a_ack: assert property (p_ack) else $error("ack without payload");
  property p_cdb; $rose(cdb_valid_out) |-> cdb_valid_out[*6]; endproperty
  a_cdb: assert property (p_cdb) else $error("short descriptor");
  property p_sel; sel_valid_out |-> ##[1:2] (tag_valid_out || msg_valid_out || cdb_valid_out);
  endproperty
  a_sel: assert property (p_sel) else $error("nothing after select");
endmodule
bind spd_decoder spd_chk u_chk(.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .blk_go_in(blk_go_in), .global_release_permit_in(global_release_permit_in),
  .unit_tagging_enabled_in(unit_tagging_enabled_in), .busy_out(busy_out),
  .sel_valid_out(sel_valid_out), .allow_disconnect_out(allow_disconnect_out),
  .tag_valid_out(tag_valid_out), .tag_msg_out(tag_msg_out), .msg_valid_out(msg_valid_out),
  .cdb_valid_out(cdb_valid_out), .payload_present_out(payload_present_out),
  .xfer_ack_out(xfer_ack_out), .done_out(done_out));

/* File: test/spd_tgt_model.sv */
// Behavioural SCSI target for the decoder bench
`timescale 1ns/1ps
`include "spd_defines.vh"
module spd_tgt(input wire clk_in, output logic [2:0] phase_out, output logic req_out,
  output logic done_out);
  initial begin
    phase_out = `SPD_PH_STAT;
    req_out = 0;
    done_out = 0;
  end
  // Waits out the descriptor first; one request at a time so no ack is double counted
  task automatic serve(input int n, input bit [2:0] ph, input int gap);
    repeat (20) @(negedge clk_in);
    repeat (n) begin
      @(negedge clk_in);
      phase_out = ph;
      req_out = 1;
      // Three cycles high and four plus gap cycles low so the decoder's pin filter sees each request
      repeat (3) @(negedge clk_in);
      req_out = 0;
      repeat (3 + gap) @(negedge clk_in);
    end
    @(negedge clk_in);
    done_out = 1;
    repeat (3) @(negedge clk_in);
    done_out = 0;
    phase_out = `SPD_PH_STAT;
  endtask
endmodule

/* File: test/spd_decoder_bench.sv */
// Self-checking bench for the parameter block decoder
`timescale 1ns/1ps
`include "spd_defines.vh"
module spd_decoder_bench;
  logic clk = 0, rstn = 0, wr = 0, go = 0, perm = 0, tagen = 0;
  logic [4:0] ofs = 0;
  logic [31:0] dat = 0;
  wire [2:0] ph, unit;
  wire req, tdone, busy, selv, adis, tagv, msgv, cdbv, pp, tt, ack, done;
  wire [7:0] tgt, tmsg, mcode, cbyte, err;
  wire [31:0] addr, ident;
  int n_errors = 0, checked = 0, cyc = 0, n_ack, n_tag, n_msg;
  logic [7:0] cq[$];
  bit [7:0] ops[7] = '{8'haa, 8'hb3, 8'ha8, 8'he4, 8'hc0, 8'h60, 8'hff};
  bit [1:0] dd[7] = '{3, 3, 2, 2, 0, 0, 0};
  bit [7:0] mc[4] = '{8'h06, 8'h0c, 8'h0e, 8'h20};
  always #2 clk = ~clk;
  spd_tgt tm(.clk_in(clk), .phase_out(ph), .req_out(req), .done_out(tdone));
  spd_decoder dut(.clk_sys_in(clk), .rstn_in(rstn), .blk_wr_in(wr), .blk_ofs_in(ofs),
    .blk_data_in(dat), .blk_go_in(go), .global_release_permit_in(perm),
    .unit_tagging_enabled_in(tagen), .tgt_phase_in(ph), .tgt_req_in(req),
    .tgt_done_in(tdone), .busy_out(busy), .sel_valid_out(selv), .sel_target_out(tgt),
    .sel_unit_out(unit), .allow_disconnect_out(adis), .tag_valid_out(tagv),
    .tag_msg_out(tmsg), .msg_valid_out(msgv), .msg_code_out(mcode), .cdb_valid_out(cdbv),
    .cdb_byte_out(cbyte), .payload_present_out(pp), .to_target_out(tt),
    .xfer_addr_out(addr), .xfer_ack_out(ack), .done_out(done), .error_code_out(err),
    .ident_out(ident));
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      tally_and_finish();
    end
    if (ack) n_ack++;
    if (tagv) n_tag++;
    if (msgv) n_msg++;
    if (cdbv) cq.push_back(cbyte);
  end
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [31:0] w1, w3, w4, input int n, input bit [2:0] p, int g);
    logic [31:0] w[7];
    w = '{32'h1234_5678, w1, 32'h0000_1000, w3, w4, 32'h0706_0504, 32'h0b0a_0908};
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      wr = 1;
      ofs = 5'(i * 4);
      dat = w[i];
    end
    @(negedge clk);
    wr = 0;
    go = 1;
    {n_ack, n_tag, n_msg} = 0;
    cq = {};
    @(negedge clk);
    go = 0;
    fork
      if (n >= 0) tm.serve(n, p, g);
      begin
        for (int k = 0; k < 300 && done !== 1; k++) @(negedge clk);
        if (done !== 1) n_errors++;
      end
    join
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    for (int i = 0; i < 7; i++) begin
      run(32'h5a00_0000, 0, {24'h030201, ops[i]}, 0, 0, 0);
      check({pp, tt}, dd[i]);
      check(cq.size(), 12);
      check({cq[0], cq[11]}, {ops[i], 8'h0b});
      check({tgt, 8'(n_tag)}, 16'h5a00);
    end
    perm = 1;
    tagen = 1;
    // Override turns a read opcode into a write, no count limit
    run(32'h4200_0704, 0, 32'h0302_01a8, 3, `SPD_PH_DOUT, 0);
    check({pp, tt, adis}, 3'h7);
    check({err, 8'(n_ack)}, 16'h0003);
    check(addr, 32'h1003);
    check({8'(n_tag), tmsg}, {8'h01, `SPD_MSG_ORDERED});
    run(32'h4200_000a, 2, 32'h0302_01aa, 4, `SPD_PH_DOUT, 2);
    check({err, 8'(n_ack)}, {`SPD_ERR_OVERRUN, 8'h02});
    check({adis, tmsg}, {1'b0, `SPD_MSG_HEAD});
    run(32'h4200_000c, 0, 32'h0302_01aa, 1, `SPD_PH_DIN, 0);
    check({err, 8'(n_tag)}, {`SPD_ERR_PHASE, 8'h00});
    for (int i = 0; i < 4; i++) begin
      run(32'h5aff_ff0f, 0, {16'h0000, 8'ha0, mc[i]}, -1, 0, 0);
      check({err, 8'(n_msg)}, (i == 3) ? 16'h0100 : 16'h0001);
      check({8'(cq.size()), 8'(n_tag)}, 0);
      if (i < 3) check({mcode, 5'h0, unit, tgt}, {mc[i], 8'h05, 8'h5a});
      check(ident, 32'h1234_5678);
    end
    tally_and_finish();
  end
endmodule
